// [hw/idr_pkg.sv]
// Constants for the interrupt and DMA routing block.
// Assumes host I/O cycles arrive already decoded from the LPC framing.
package idr_pkg;
    // ------------------------------------------------------------
    // Configuration port
    // ------------------------------------------------------------
    localparam logic [15:0] CFG_PORT_LO = 16'h002E;
    localparam logic [15:0] CFG_PORT_HI = 16'h004E;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_LDN = 8'h07;
    localparam logic [7:0] IDX_OSC_CFG = 8'h24;
    localparam logic [7:0] IDX_CFG_ADDR_A = 8'h26;
    localparam logic [7:0] IDX_CFG_ADDR_B = 8'h27;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW = 8'h61;
    localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
    localparam logic [7:0] IDX_DMA_SEL = 8'h74;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OSC_QUAL16_BIT = 6;
    localparam int ACT_BIT = 0;
    // ------------------------------------------------------------
    // Logical device numbers
    // ------------------------------------------------------------
    localparam logic [7:0] LDN_FLOPPY = 8'h00;
    localparam logic [7:0] LDN_PPORT = 8'h03;
    localparam logic [7:0] LDN_UART1 = 8'h04;
    localparam logic [7:0] LDN_UART2 = 8'h05;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] IRQ_RST_FLOPPY = 4'h6;
    localparam logic [3:0] IRQ_RST_OTHER = 4'h0;
    localparam logic [2:0] DMA_RST_FLOPPY = 3'h2;
    localparam logic [2:0] DMA_RST_OTHER = 3'h4;
    localparam logic [7:0] OSC_CFG_RST = 8'h00;
    // ------------------------------------------------------------
    // Parallel extended-control modes
    // ------------------------------------------------------------
    localparam logic [2:0] ECR_FIFO = 3'h2;
    localparam logic [2:0] ECR_ECP = 3'h3;
    localparam logic [2:0] ECR_TEST = 3'h6;
    // ------------------------------------------------------------
    // Base decode alignment masks (low address bits ignored)
    // ------------------------------------------------------------
    localparam logic [11:0] MASK_8B = 12'hFF8;
    localparam logic [11:0] MASK_4B = 12'hFFC;
endpackage

// [hw/idr_routing.sv]
// Resource routing: config port, base decode, IRQ and DMA steering.
// Assumes one-cycle I/O read/write strobes synchronous to ref_clk_i.
//
// Overview of operation
// - Base addresses of logical devices are decoded on address bits 11:0.
// - Global config bit 6 set also requires address bits 15:12 zero.
// - Config port starts at 0x02E with strap low, 0x04E with strap high.
// - Writing global indices config_port_addr_a and config_port_addr_b moves the config port.
// - Index port at config address selects register; data port one above.
// - Interrupt select bits 3:0 at 0x70: zero none, else that line.
// - Interrupt select resets to zero, floppy device to 0x06.
// - Routed interrupts are active high; system management output is low.
// - Interrupt needs nonzero select and the device's enable; floppy uses gate.
// - Parallel interrupt needs enable except in modes 010, 011, 110; ECP mode also needs service bit clear.
// - Serial interrupt needs an enable bit 0-3 and auxiliary output two.
// - Lines not selected and used by any device stay undriven.
// - DMA select bits 2:0 at 0x74: one to three channel, four up none.
// - DMA select resets to 0x02 for floppy, 0x04 for devices three to five.
// - DMA active only with select one to three and device DMA enable.
// - Parallel DMA in ECP mode needs the extended DMA enable bit.
// - DMA channels not selected and used by any device stay disabled.
// - A device's own disable bit removes its interrupt and DMA too.
// - Floppy gate low or power down kills its IRQ, DMA and acknowledges.
// - Serial auxiliary output two low suppresses that serial interrupt.
// - Standard and EPP parallel modes gate interrupt by enable bit.
// - Modes 010 and 110 interrupt always on, 011 unless service bit set; DMA enable drives request.
`timescale 1ns/1ns
module idr_routing #(
    parameter int NUM_DEV = 4
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic soft_rst_i,
    input wire logic cfg_port_strap_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_ack_o,
    output logic [3:0] dev_hit_o,
    input wire logic floppy_dma_gate_i,
    input wire logic floppy_pwrdn_i,
    input wire logic pport_irq_enable_i,
    input wire logic [2:0] pport_ecr_mode_i,
    input wire logic ext_service_int_i,
    input wire logic ext_dma_enable_i,
    input wire logic [3:0] uart1_int_enable_reg_i,
    input wire logic [3:0] uart2_int_enable_reg_i,
    input wire logic [1:0] uart_aux_out_two_i,
    input wire logic [3:0] dev_int_i,
    input wire logic [3:0] dev_drq_i,
    input wire logic [3:0] dma_ack_i,
    input wire logic smi_event_i,
    output logic [15:0] irq_o,
    output logic [15:0] irq_oe_o,
    output logic sys_mgmt_int_n_o,
    output logic [3:0] dma_req_o,
    output logic [3:0] dma_en_o,
    output logic [3:0] dev_dack_o
);
    initial begin
        if (NUM_DEV != 4) begin
            $error("idr_routing serves exactly four logical devices");
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Map logical device number to local slot; slot NUM_DEV is none
    function automatic logic [2:0] ldn_slot(input logic [7:0] ldn);
        if (ldn == idr_pkg::LDN_FLOPPY) begin
            ldn_slot = 3'd0;
        end else if (ldn == idr_pkg::LDN_PPORT) begin
            ldn_slot = 3'd1;
        end else if (ldn == idr_pkg::LDN_UART1) begin
            ldn_slot = 3'd2;
        end else if (ldn == idr_pkg::LDN_UART2) begin
            ldn_slot = 3'd3;
        end else begin
            ldn_slot = 3'd4;
        end
    endfunction

    function automatic logic base_hit(input logic [15:0] addr,
                                      input logic [15:0] base,
                                      input logic [11:0] mask,
                                      input logic qual16);
        base_hit = ((addr[11:0] & mask) == (base[11:0] & mask))
                   && !(qual16 && addr[15:12] != 4'h0);
    endfunction

    function automatic logic [3:0] irq_default(input int d);
        irq_default = (d == 0) ? idr_pkg::IRQ_RST_FLOPPY
                               : idr_pkg::IRQ_RST_OTHER;
    endfunction

    function automatic logic [2:0] dma_default(input int d);
        dma_default = (d == 0) ? idr_pkg::DMA_RST_FLOPPY
                               : idr_pkg::DMA_RST_OTHER;
    endfunction

    // ------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------
    logic [15:0] cfg_base_r;
    logic strap_done_r;
    logic [7:0] index_r;
    logic [7:0] ldn_r;
    logic [7:0] osc_global_cfg_r;
    logic [NUM_DEV-1:0] act_r;
    logic [15:0] base_r [NUM_DEV];
    logic [3:0] irq_sel_r [NUM_DEV];
    logic [2:0] dma_sel_r [NUM_DEV];

    logic idx_port;
    logic dat_port;
    logic [2:0] slot;
    logic slot_ok;
    logic dat_wr;

    assign idx_port = (io_addr_i == cfg_base_r);
    assign dat_port = (io_addr_i == cfg_base_r + 16'h0001);
    assign slot = ldn_slot(ldn_r);
    assign slot_ok = (slot < 3'd4);
    assign dat_wr = ce_i && io_wr_i && dat_port;

    // Config port address; strap caught on first enabled cycle
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_base_r <= idr_pkg::CFG_PORT_LO;
            strap_done_r <= 1'b0;
        end else if (ce_i) begin
            if (!strap_done_r) begin
                strap_done_r <= 1'b1;
                cfg_base_r <= cfg_port_strap_i ? idr_pkg::CFG_PORT_HI
                                               : idr_pkg::CFG_PORT_LO;
            end else if (dat_wr && index_r == idr_pkg::IDX_CFG_ADDR_A) begin
                cfg_base_r[7:0] <= io_wdata_i;
            end else if (dat_wr && index_r == idr_pkg::IDX_CFG_ADDR_B) begin
                cfg_base_r[15:8] <= io_wdata_i;
            end
        end
    end

    // Index, device select and global oscillator config
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            index_r <= 8'h00;
            ldn_r <= 8'h00;
            osc_global_cfg_r <= idr_pkg::OSC_CFG_RST;
        end else if (ce_i) begin
            if (io_wr_i && idx_port) begin
                index_r <= io_wdata_i;
            end else if (dat_wr && index_r == idr_pkg::IDX_LDN) begin
                ldn_r <= io_wdata_i;
            end else if (dat_wr && index_r == idr_pkg::IDX_OSC_CFG) begin
                osc_global_cfg_r <= io_wdata_i;
            end
        end
    end

    // Per-device registers; soft reset restores routing defaults
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int d = 0; d < NUM_DEV; d++) begin
                act_r[d] <= 1'b0;
                base_r[d] <= 16'h0000;
                irq_sel_r[d] <= irq_default(d);
                dma_sel_r[d] <= dma_default(d);
            end
        end else if (ce_i) begin
            if (soft_rst_i) begin
                for (int d = 0; d < NUM_DEV; d++) begin
                    act_r[d] <= 1'b0;
                    irq_sel_r[d] <= irq_default(d);
                    dma_sel_r[d] <= dma_default(d);
                end
            end else if (dat_wr && slot_ok) begin
                if (index_r == idr_pkg::IDX_ACTIVATE) begin
                    act_r[slot[1:0]] <= io_wdata_i[idr_pkg::ACT_BIT];
                end else if (index_r == idr_pkg::IDX_BASE_HIGH) begin
                    base_r[slot[1:0]][15:8] <= io_wdata_i;
                end else if (index_r == idr_pkg::IDX_BASE_LOW) begin
                    base_r[slot[1:0]][7:0] <= io_wdata_i;
                end else if (index_r == idr_pkg::IDX_IRQ_SEL) begin
                    irq_sel_r[slot[1:0]] <= io_wdata_i[3:0];
                end else if (index_r == idr_pkg::IDX_DMA_SEL) begin
                    dma_sel_r[slot[1:0]] <= io_wdata_i[2:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Host read path
    // ------------------------------------------------------------
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = 8'h00;
        if (idx_port) begin
            rd_nxt = index_r;
        end else if (index_r == idr_pkg::IDX_LDN) begin
            rd_nxt = ldn_r;
        end else if (index_r == idr_pkg::IDX_OSC_CFG) begin
            rd_nxt = osc_global_cfg_r;
        end else if (index_r == idr_pkg::IDX_CFG_ADDR_A) begin
            rd_nxt = cfg_base_r[7:0];
        end else if (index_r == idr_pkg::IDX_CFG_ADDR_B) begin
            rd_nxt = cfg_base_r[15:8];
        end else if (!slot_ok) begin
            rd_nxt = 8'h00;
        end else if (index_r == idr_pkg::IDX_ACTIVATE) begin
            rd_nxt = {7'h00, act_r[slot[1:0]]};
        end else if (index_r == idr_pkg::IDX_BASE_HIGH) begin
            rd_nxt = base_r[slot[1:0]][15:8];
        end else if (index_r == idr_pkg::IDX_BASE_LOW) begin
            rd_nxt = base_r[slot[1:0]][7:0];
        end else if (index_r == idr_pkg::IDX_IRQ_SEL) begin
            rd_nxt = {4'h0, irq_sel_r[slot[1:0]]};
        end else if (index_r == idr_pkg::IDX_DMA_SEL) begin
            rd_nxt = {5'h00, dma_sel_r[slot[1:0]]};
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            io_rdata_o <= 8'h00;
            io_ack_o <= 1'b0;
        end else if (ce_i) begin
            io_ack_o <= (io_rd_i || io_wr_i) && (idx_port || dat_port);
            io_rdata_o <= (io_rd_i && (idx_port || dat_port)) ? rd_nxt
                                                               : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Device base decode
    // ------------------------------------------------------------
    logic [NUM_DEV-1:0] live;
    logic [3:0] hit_nxt;
    logic qual16;
    assign qual16 = osc_global_cfg_r[idr_pkg::OSC_QUAL16_BIT];
    always_comb begin
        for (int d = 0; d < NUM_DEV; d++) begin
            live[d] = act_r[d] && (base_r[d] != 16'h0000);
            hit_nxt[d] = live[d] && (io_rd_i || io_wr_i) &&
                base_hit(io_addr_i, base_r[d],
                         (d == 1) ? idr_pkg::MASK_4B : idr_pkg::MASK_8B,
                         qual16);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dev_hit_o <= 4'h0;
        end else if (ce_i) begin
            dev_hit_o <= hit_nxt;
        end
    end

    // ------------------------------------------------------------
    // Per-device enables
    // ------------------------------------------------------------
    logic floppy_ok;
    logic pp_irq_ok;
    logic pp_on_mode;
    logic [NUM_DEV-1:0] irq_ok;
    logic [NUM_DEV-1:0] dma_ok;

    assign floppy_ok = floppy_dma_gate_i && !floppy_pwrdn_i;
    assign pp_on_mode = (pport_ecr_mode_i == idr_pkg::ECR_FIFO) ||
                        (pport_ecr_mode_i == idr_pkg::ECR_ECP) ||
                        (pport_ecr_mode_i == idr_pkg::ECR_TEST);
    // Other modes (standard, EPP) follow the control-port enable
    assign pp_irq_ok = (pp_on_mode || pport_irq_enable_i) &&
        !(pport_ecr_mode_i == idr_pkg::ECR_ECP && ext_service_int_i);
    assign irq_ok[0] = floppy_ok;
    assign irq_ok[1] = pp_irq_ok;
    assign irq_ok[2] = (|uart1_int_enable_reg_i) && uart_aux_out_two_i[0];
    assign irq_ok[3] = (|uart2_int_enable_reg_i) && uart_aux_out_two_i[1];
    assign dma_ok[0] = floppy_ok;
    assign dma_ok[1] = ext_dma_enable_i;
    assign dma_ok[2] = 1'b1;
    assign dma_ok[3] = 1'b1;

    // ------------------------------------------------------------
    // Line steering
    // ------------------------------------------------------------
    logic [15:0] irq_nxt;
    logic [15:0] oe_nxt;
    logic [3:0] dreq_nxt;
    logic [3:0] den_nxt;
    logic [3:0] dack_nxt;
    always_comb begin
        irq_nxt = 16'h0000;
        oe_nxt = 16'h0000;
        dreq_nxt = 4'h0;
        den_nxt = 4'h0;
        dack_nxt = 4'h0;
        for (int d = 0; d < NUM_DEV; d++) begin
            if (live[d] && irq_ok[d] && irq_sel_r[d] != 4'h0) begin
                oe_nxt[irq_sel_r[d]] = 1'b1;
                irq_nxt[irq_sel_r[d]] = irq_nxt[irq_sel_r[d]] ||
                                        dev_int_i[d];
            end
            // Select zero and four-seven never reach a channel
            if (live[d] && dma_ok[d] && dma_sel_r[d] != 3'h0 &&
                dma_sel_r[d] < 3'h4) begin
                den_nxt[dma_sel_r[d][1:0]] = 1'b1;
                dreq_nxt[dma_sel_r[d][1:0]] =
                    dreq_nxt[dma_sel_r[d][1:0]] || dev_drq_i[d];
                dack_nxt[d] = dma_ack_i[dma_sel_r[d][1:0]];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 16'h0000;
            irq_oe_o <= 16'h0000;
            dma_req_o <= 4'h0;
            dma_en_o <= 4'h0;
            dev_dack_o <= 4'h0;
        end else if (ce_i) begin
            irq_o <= irq_nxt;
            irq_oe_o <= oe_nxt;
            dma_req_o <= dreq_nxt;
            dma_en_o <= den_nxt;
            dev_dack_o <= dack_nxt;
        end
    end

    // System management output is active low
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sys_mgmt_int_n_o <= 1'b1;
        end else if (ce_i) begin
            sys_mgmt_int_n_o <= !smi_event_i;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_strap_port: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && !strap_done_r |=> cfg_base_r ==
            ($past(cfg_port_strap_i) ? 16'h004E : 16'h002E))
        else $error("config port not placed by strap");
    a_port_move: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        strap_done_r && dat_wr && !(io_wr_i && idx_port) &&
        index_r == 8'h26 |=> cfg_base_r[7:0] == $past(io_wdata_i))
        else $error("config port low byte not moved");
    a_qual_high: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && qual16 && io_addr_i[15:12] != 4'h0 |=> dev_hit_o == 4'h0)
        else $error("device hit with upper address bits set");
    a_irq_undriven: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && oe_nxt == 16'h0000 |=> irq_o == 16'h0000 &&
            irq_oe_o == 16'h0000)
        else $error("interrupt driven while unused");
    a_irq_zero_none: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        irq_oe_o[0] == 1'b0 && irq_o[0] == 1'b0)
        else $error("select zero drove a line");
    a_floppy_gate: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && !floppy_dma_gate_i && irq_sel_r[0] != 4'h0 &&
        irq_sel_r[1] != irq_sel_r[0] && irq_sel_r[2] != irq_sel_r[0] &&
        irq_sel_r[3] != irq_sel_r[0] |=> !irq_oe_o[$past(irq_sel_r[0])]
            && !dev_dack_o[0])
        else $error("floppy routed with gate low");
    a_uart_aux: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && !uart_aux_out_two_i[0] && !dev_int_i[0] && !dev_int_i[1]
        && !dev_int_i[3] |=> irq_o == 16'h0000)
        else $error("serial interrupt passed with aux output low");
    a_dma_reserved: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        dma_req_o[0] == 1'b0 && dma_en_o[0] == 1'b0)
        else $error("reserved DMA select drove a request");
    a_smi_low: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && smi_event_i ##1 ce_i |=> !$past(sys_mgmt_int_n_o) ||
            !ce_i)
        else $error("system management output not active low");
    a_irq_default: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && soft_rst_i |=> irq_sel_r[0] == 4'h6 &&
            irq_sel_r[1] == 4'h0 && dma_sel_r[0] == 3'h2 &&
            dma_sel_r[1] == 3'h4 && dma_sel_r[3] == 3'h4)
        else $error("soft reset left wrong routing defaults");
endmodule

// [testbench/idr_host.sv]
// Host side model: issues decoded I/O cycles to the routing block.
// Assumes a strobe is taken at the next edge and answered at that same edge.
`timescale 1ns/1ns
module idr_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic ack_i,
    output logic [15:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial begin
        addr_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // ----------------------------------------
    // One I/O cycle; idle bus shows inverted values
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [15:0] a,
                        input logic [7:0] d, output logic ack,
                        output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wr_o <= wr;
        rd_o <= ~wr;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        ack = ack_i;
        q = rdata_i;
    endtask
endmodule

// [testbench/tb_top.sv]
// Testbench for the routing block: config port, decode, IRQ and DMA.
// Assumes the host model drives I/O cycles at the config port.
`timescale 1ns/1ns
module tb_top;
    logic clk, rst, ce, srst, strap, gate, pdn, pie, sint, dmae, smi;
    logic wr, rd, ack, a;
    logic [15:0] addr, irq, oe, port;
    logic [7:0] wd, rdata, q;
    logic [3:0] hit, ie1, ie2, dint, drq, dak, dreq, den, dack;
    logic [2:0] ecr;
    logic [1:0] uart_aux_out_two;
    logic smi_n;
    int fails, n_compared;
    idr_routing #(.NUM_DEV(4)) i_dut (.ref_clk_i(clk), .sys_rst_i(rst),
        .ce_i(ce), .soft_rst_i(srst), .cfg_port_strap_i(strap),
        .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wd),
        .io_rdata_o(rdata), .io_ack_o(ack), .dev_hit_o(hit),
        .floppy_dma_gate_i(gate), .floppy_pwrdn_i(pdn),
        .pport_irq_enable_i(pie), .pport_ecr_mode_i(ecr),
        .ext_service_int_i(sint), .ext_dma_enable_i(dmae),
        .uart1_int_enable_reg_i(ie1), .uart2_int_enable_reg_i(ie2),
        .uart_aux_out_two_i(uart_aux_out_two), .dev_int_i(dint), .dev_drq_i(drq),
        .dma_ack_i(dak), .smi_event_i(smi), .irq_o(irq), .irq_oe_o(oe),
        .sys_mgmt_int_n_o(smi_n), .dma_req_o(dreq), .dma_en_o(den),
        .dev_dack_o(dack));
    idr_host i_host (.clk_i(clk), .rdata_i(rdata), .ack_i(ack),
        .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
    task automatic chk(input string what, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask
    // Index write then data access; both must be acknowledged
    task automatic cfg(input logic [7:0] idx, d, input logic w);
        logic a0;
        i_host.xfer(1'b1, port, idx, a0, q);
        i_host.xfer(w, port + 16'h0001, d, a, q);
        chk("ack", 16'h0003, {14'h0, a0, a});
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_defaults();
        cfg(8'h07, 8'h00, 1'b1);
        cfg(8'h70, 8'h00, 1'b0);
        chk("irq_sel0", 16'h0006, {8'h0, q});
        cfg(8'h74, 8'h00, 1'b0);
        chk("dma_sel0", 16'h0002, {8'h0, q});
        cfg(8'h07, 8'h03, 1'b1);
        cfg(8'h70, 8'h00, 1'b0);
        chk("irq_sel3", 16'h0000, {8'h0, q});
        cfg(8'h74, 8'h00, 1'b0);
        chk("dma_sel3", 16'h0004, {8'h0, q});
    endtask
    task automatic t_floppy();
        cfg(8'h07, 8'h00, 1'b1);
        cfg(8'h60, 8'h03, 1'b1);
        cfg(8'h61, 8'hF0, 1'b1);
        cfg(8'h30, 8'h01, 1'b1);
        @(posedge clk);
        gate <= 1'b1;
        dint <= 4'h1;
        drq <= 4'h1;
        dak <= 4'h4;
        settle();
        chk("irq", 16'h0040, irq);
        chk("irq_oe", 16'h0040, oe);
        chk("dack", 16'h0001, {12'h0, dack});
        for (int s = 0; s < 16; s++) begin
            cfg(8'h70, 8'(s), 1'b1);
            settle();
            chk("irq_line", s == 0 ? 16'h0 : 16'(1 << s), oe);
        end
        for (int s = 0; s < 8; s++) begin
            cfg(8'h74, 8'(s), 1'b1);
            settle();
            chk("dma", (s > 0 && s < 4) ? 16'(1 << s) : 16'h0,
                {12'h0, dreq});
            chk("dma_en", (s > 0 && s < 4) ? 16'(1 << s) : 16'h0,
                {12'h0, den});
        end
        i_host.xfer(1'b0, 16'h13F2, 8'h00, a, q);
        chk("hit", 16'h0001, {12'h0, hit});
        cfg(8'h24, 8'h40, 1'b1);
        i_host.xfer(1'b0, 16'h13F2, 8'h00, a, q);
        chk("hit_q16", 16'h0000, {12'h0, hit});
        cfg(8'h24, 8'h00, 1'b1);
        cfg(8'h74, 8'h02, 1'b1);
        @(posedge clk);
        pdn <= 1'b1;
        settle();
        chk("pdn", 16'h0, {oe[15:12], irq[15:12], dreq, dack});
        @(posedge clk);
        pdn <= 1'b0;
        gate <= 1'b0;
        settle();
        chk("gate", 16'h0, {oe[15:12], irq[15:12], dreq, dack});
    endtask
    task automatic t_uart_pport();
        cfg(8'h07, 8'h04, 1'b1);
        cfg(8'h60, 8'h02, 1'b1);
        cfg(8'h61, 8'hF8, 1'b1);
        cfg(8'h30, 8'h01, 1'b1);
        cfg(8'h70, 8'h04, 1'b1);
        @(posedge clk);
        dint <= 4'h4;
        ie1 <= 4'h8;
        uart_aux_out_two <= 2'b01;
        settle();
        chk("uart", 16'h0010, irq);
        @(posedge clk);
        uart_aux_out_two <= 2'b00;
        settle();
        chk("uart_uart_aux_out_two", 16'h0000, irq);
        cfg(8'h07, 8'h03, 1'b1);
        cfg(8'h60, 8'h03, 1'b1);
        cfg(8'h61, 8'h78, 1'b1);
        cfg(8'h30, 8'h01, 1'b1);
        cfg(8'h70, 8'h07, 1'b1);
        cfg(8'h74, 8'h03, 1'b1);
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            ecr <= 3'(m);
            dint <= 4'h2;
            settle();
            chk("pp_mode", (m == 2 || m == 3 || m == 6) ? 16'h0080 : 16'h0,
                irq);
        end
        @(posedge clk);
        pie <= 1'b1;
        sint <= 1'b1;
        ecr <= 3'h3;
        drq <= 4'h2;
        settle();
        chk("pp_svc", 16'h0, {irq[7], dreq});
        @(posedge clk);
        dmae <= 1'b1;
        settle();
        chk("pp_dma", 16'h0008, {12'h0, dreq});
    endtask
    task automatic t_move_smi();
        cfg(8'h26, 8'h4E, 1'b1);
        port = 16'h004E;
        cfg(8'h27, 8'h00, 1'b1);
        cfg(8'h26, 8'h00, 1'b0);
        chk("port", 16'h004E, {8'h0, q});
        @(posedge clk);
        smi <= 1'b1;
        settle();
        chk("smi_n", 16'h0, {15'h0, smi_n});
    endtask
    task automatic t_soft_ce();
        @(posedge clk);
        ce <= 1'b0;
        smi <= 1'b0;
        settle();
        chk("ce_hold", 16'h0, {15'h0, smi_n});
        @(posedge clk);
        ce <= 1'b1;
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        cfg(8'h07, 8'h03, 1'b1);
        cfg(8'h70, 8'h00, 1'b0);
        chk("srst_irq3", 16'h0000, {8'h0, q});
        cfg(8'h74, 8'h00, 1'b0);
        chk("srst_dma3", 16'h0004, {8'h0, q});
        chk("smi_idle", 16'h0001, {15'h0, smi_n});
        @(posedge clk);
        rst <= 1'b1;
        strap <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        cfg(8'h07, 8'h00, 1'b0);
        chk("strap_ldn", 16'h0000, {8'h0, q});
    endtask
    task automatic summarize();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        fails++;
        summarize();
    end
    initial begin
        {rst, ce, srst, strap, gate, pdn, pie, sint, dmae} = 9'h180;
        smi = 1'b0;
        {ie1, ie2, dint, drq, dak, ecr, uart_aux_out_two} = 25'h0;
        port = 16'h002E;
        fails = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_defaults();
        t_floppy();
        t_uart_pport();
        t_move_smi();
        t_soft_ce();
        summarize();
    end
endmodule
